// *** include/pls_pkg.sv ***
// package of constants, types and register map for the position limit supervisor
package pls_pkg;
   // ***********************************************************
   // widths and clock
   // ***********************************************************
   localparam int          POS_W        = 24;
   localparam int          CLK_HZ       = 25000000;
   localparam logic [7:0]  WB_AW        = 8'h08;
   // ***********************************************************
   // register byte offsets on the wishbone bus
   // ***********************************************************
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_UPPER    = 8'h04;
   localparam logic [7:0]  OFS_LOWER    = 8'h08;
   localparam logic [7:0]  OFS_TIMEOUT  = 8'h0C;
   localparam logic [7:0]  OFS_CODE     = 8'h10;
   localparam logic [7:0]  OFS_POS      = 8'h14;
   localparam logic [7:0]  OFS_STATUS   = 8'h18;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0]  OFS_IRQ_MASK = 8'h20;
   // ***********************************************************
   // control fields
   // ***********************************************************
   localparam int          CTRL_MM      = 0;
   localparam int          CTRL_UP_NC   = 1;
   localparam int          CTRL_LO_NC   = 2;
   localparam int          CTRL_EXIT    = 3;
   localparam int          CTRL_ACK     = 4;
   // status / irq fields
   localparam int          ST_PROG      = 0;
   localparam int          ST_JAM       = 1;
   localparam int          ST_OVER      = 2;
   localparam int          ST_UNDER     = 3;
   localparam int          IRQ_W        = 3;
   localparam int          IRQ_JAM      = 0;
   localparam int          IRQ_OVER     = 1;
   localparam int          IRQ_UNDER    = 2;
   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [31:0] ACCESS_CODE_DEF = 32'h0000_1234; // arbitrary
   localparam logic [POS_W-1:0] UPPER_RST   = 24'h7FFFFF;
   localparam logic [POS_W-1:0] LOWER_RST   = 24'h800000;
   localparam logic [31:0] TIMEOUT_RST     = 32'h0098_9680; // ten million cycles
   // millimetres per inch scaling: mm = in * 254 / 10 (position in 0.001 units)
   localparam logic [15:0] MM_NUM       = 16'h00FE;
   localparam logic [15:0] MM_DEN       = 16'h000A;
   // ***********************************************************
   // carrier types
   // ***********************************************************
   typedef struct packed {
      logic             mm_sel;
      logic             upper_nc;
      logic             lower_nc;
      logic [POS_W-1:0] upper;
      logic [POS_W-1:0] lower;
      logic [31:0]      timeout;
   } pls_cfg_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } pls_wb_req_t;
   typedef enum logic [2:0] {
      MD_IDLE  = 3'b001,
      MD_TIME  = 3'b010,
      MD_JAM   = 3'b100
   } pls_md_state_t;
endpackage : pls_pkg

// *** logic/pls_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module pls_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;
   // first stage is read only by the second
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : pls_sync

// *** logic/pls_movetimer.sv ***
// move-detection timer: counts from motor power until motion, flags jam
`timescale 1ns/1ns
module pls_movetimer (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        motor_on_i,
   input  wire logic        motion_i,
   input  wire logic [31:0] timeout_i,
   input  wire logic        ack_i,
   output logic             jam_o,
   output logic             jam_set_o
);
   pls_pkg::pls_md_state_t state;
   logic [31:0]            cnt;
   logic                   motor_q;
   // timer state machine; jam holds until ack even with motor off
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state     <= pls_pkg::MD_IDLE;
         cnt       <= '0;
         motor_q   <= 1'b0;
         jam_set_o <= 1'b0;
      end else begin
         motor_q   <= motor_on_i;
         jam_set_o <= 1'b0;
         unique case (state)
            pls_pkg::MD_IDLE: begin
               cnt <= '0;
               if (motor_on_i && !motor_q && !motion_i) begin
                  state <= pls_pkg::MD_TIME; // [RQ5]
               end
            end
            pls_pkg::MD_TIME: begin
               cnt <= cnt + 32'h0000_0001;
               if (motion_i || !motor_on_i) begin
                  state <= pls_pkg::MD_IDLE; // [RQ5]
               end else if (cnt + 32'h0000_0001 >= timeout_i) begin
                  state     <= pls_pkg::MD_JAM; // [RQ6]
                  jam_set_o <= 1'b1;
               end
            end
            pls_pkg::MD_JAM: begin
               if (ack_i) begin
                  state <= pls_pkg::MD_IDLE; // [RQ12]
               end
            end
         endcase
      end
   end
   assign jam_o = (state == pls_pkg::MD_JAM); // [RQ12]
endmodule : pls_movetimer

// *** logic/pls_top.sv ***
// position limit supervisor top: wishbone registers, hold, limits, relays
`timescale 1ns/1ns
// Overview of operation
// RQ1: de-energize limit output when position passes upper or lower limit.
// RQ2: drive limit relays only when the relay option is fitted.
// RQ3: while hold is asserted keep showing the last captured position.
// RQ4: after hold releases, follow the transducer reading continuously again.
// RQ5: move timer starts on motor power, stops when motion is sensed.
// RQ6: timeout without motion de-energizes limits and raises error indication.
// RQ7: position reported and compared in inches or millimetres, selectable.
// RQ8: program mode entered only by writing the matching access code.
// RQ9: each limit output polarity selectable normally open or closed.
// RQ10: program indicator lit exactly in program mode; settings only then.
// RQ11: limits, timeout, unit and polarity writable only in program mode.
// RQ12: jam error latched with limits off until acknowledge or reset.
module pls_top #(
   parameter logic [31:0] ACCESS_CODE = pls_pkg::ACCESS_CODE_DEF
) (
   input  wire logic                     mclk_i,
   input  wire logic                     rst_b_i,
   // wishbone classic slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   // transducer and press
   input  wire logic [pls_pkg::POS_W-1:0] pos_i,
   input  wire logic                     hold_i,
   input  wire logic                     motor_on_i,
   input  wire logic                     relay_fitted_i,
   // outputs
   output logic      [pls_pkg::POS_W-1:0] pos_o,
   output logic                          upper_relay_o,
   output logic                          lower_relay_o,
   output logic                          relay_oe_o,
   output logic                          prog_led_o,
   output logic                          jam_err_o,
   output logic                          irq_o
);
   // ***********************************************************
   // signals
   // ***********************************************************
   pls_pkg::pls_cfg_t        cfg;
   pls_pkg::pls_wb_req_t     req;
   logic                     prog;
   logic [2:0]               pin_s;
   logic                     hold_s;
   logic                     motor_s;
   logic                     relay_s;
   logic [pls_pkg::POS_W-1:0] pos_s1;
   logic [pls_pkg::POS_W-1:0] pos_s2;
   logic [pls_pkg::POS_W-1:0] pos_held;
   logic [pls_pkg::POS_W-1:0] pos_prev;
   logic                     motion;
   logic                     over;
   logic                     under;
   logic                     over_q;
   logic                     under_q;
   logic                     jam;
   logic                     jam_set;
   logic                     ack_jam;
   logic [pls_pkg::IRQ_W-1:0] irq_stat;
   logic [pls_pkg::IRQ_W-1:0] irq_mask;
   logic [pls_pkg::IRQ_W-1:0] irq_ev;
   logic                     wr;
   logic                     rd_sel;
   logic [31:0]              next_dat;
   logic                     upper_ok;
   logic                     lower_ok;
   logic [31:0]              upper_mrg;
   logic [31:0]              lower_mrg;

   // ***********************************************************
   // functions
   // ***********************************************************
   // unit conversion of a position for report and compare
   function automatic logic [pls_pkg::POS_W-1:0] to_unit(input logic [pls_pkg::POS_W-1:0] p,
                                                         input logic mm);
      logic signed [47:0] wide;
      // every operand signed, so positions below zero scale correctly
      wide = 48'(signed'(p)) * signed'(48'(pls_pkg::MM_NUM)) / signed'(48'(pls_pkg::MM_DEN));
      to_unit = mm ? wide[pls_pkg::POS_W-1:0] : p;
   endfunction : to_unit

   // byte-lane merge of write data into a word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // write strobe for a register that takes its bits from byte lane 0
   function automatic logic lane0_hit(input logic w, input pls_pkg::pls_wb_req_t r, input logic [7:0] a);
      lane0_hit = w && (r.adr == a) && r.sel[0];
   endfunction : lane0_hit

   // ***********************************************************
   // input synchronisers
   // ***********************************************************
   pls_sync #(.W(3)) u_sync_pins (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .d_i     ({hold_i, motor_on_i, relay_fitted_i}),
      .q_o     (pin_s)
   );
   assign hold_s  = pin_s[2];
   assign motor_s = pin_s[1];
   assign relay_s = pin_s[0];

   // position word from the front end; two stages, first read only by second
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos_s1 <= '0;
         pos_s2 <= '0;
      end else begin
         pos_s1 <= pos_i;
         pos_s2 <= pos_s1;
      end
   end

   // ***********************************************************
   // position hold and motion sense
   // ***********************************************************
   // hold freezes the indicated value; release follows the reading again
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos_held <= '0;
      end else if (!hold_s) begin
         pos_held <= pos_s2; // [RQ4]
      end else begin
         pos_held <= pos_held; // [RQ3]
      end
   end

   // any change of the live reading counts as motion
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos_prev <= '0;
      end else begin
         pos_prev <= pos_s2;
      end
   end
   assign motion = (pos_prev != pos_s2); // [RQ5]

   // reported position in the selected unit
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos_o <= '0;
      end else begin
         pos_o <= to_unit(pos_held, cfg.mm_sel); // [RQ7]
      end
   end

   // ***********************************************************
   // limit compare and relays
   // ***********************************************************
   // limits compare against the live reading, not the held value,
   // so the ram is protected even during a stamping hold
   assign over  = $signed(to_unit(pos_s2, cfg.mm_sel)) > $signed(cfg.upper); // [RQ1] [RQ7]
   assign under = $signed(to_unit(pos_s2, cfg.mm_sel)) < $signed(cfg.lower); // [RQ1]

   // last compare result, so a limit crossing raises one event
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         over_q  <= 1'b0;
         under_q <= 1'b0;
      end else begin
         over_q  <= over;
         under_q <= under;
      end
   end

   assign upper_ok = !over && !jam;  // [RQ1] [RQ6]
   assign lower_ok = !under && !jam; // [RQ1] [RQ12]

   // energized coil when ok; nc polarity inverts the sense
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         upper_relay_o <= 1'b0;
         lower_relay_o <= 1'b0;
         relay_oe_o    <= 1'b0;
      end else begin
         relay_oe_o    <= relay_s; // [RQ2]
         upper_relay_o <= relay_s & (upper_ok ^ cfg.upper_nc); // [RQ2] [RQ9]
         lower_relay_o <= relay_s & (lower_ok ^ cfg.lower_nc); // [RQ2] [RQ9]
      end
   end

   // ***********************************************************
   // move-detection timer
   // ***********************************************************
   pls_movetimer u_timer (
      .mclk_i     (mclk_i),
      .rst_b_i    (rst_b_i),
      .motor_on_i (motor_s),
      .motion_i   (motion),
      .timeout_i  (cfg.timeout),
      .ack_i      (ack_jam),
      .jam_o      (jam),
      .jam_set_o  (jam_set)
   );
   assign jam_err_o = jam; // [RQ6]

   // ***********************************************************
   // wishbone slave
   // ***********************************************************
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
   assign rd_sel = req.cyc && req.stb && !wb_ack_o;
   assign wr     = rd_sel && req.we;
   // jam acknowledge works outside program mode too, so a stuck ram can be freed
   assign ack_jam = lane0_hit(wr, req, pls_pkg::OFS_CTRL) && req.dat[pls_pkg::CTRL_ACK]; // [RQ12]

   // one-cycle ack, dropped the cycle after
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= rd_sel;
      end
   end

   // program mode: matching code enters, exit bit leaves
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prog <= 1'b0;
      end else if (wr && req.adr == pls_pkg::OFS_CODE) begin
         prog <= (merge(32'h0000_0000, req.dat, req.sel) == ACCESS_CODE); // [RQ8]
      end else if (lane0_hit(wr, req, pls_pkg::OFS_CTRL) && req.dat[pls_pkg::CTRL_EXIT]) begin
         prog <= 1'b0;
      end
   end
   assign prog_led_o = prog; // [RQ10]

   // limits widened to a bus word so byte lanes merge as on the other registers
   assign upper_mrg = merge({8'h00, cfg.upper}, req.dat, req.sel);
   assign lower_mrg = merge({8'h00, cfg.lower}, req.dat, req.sel);

   // configuration: written only in program mode, kept otherwise
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg.mm_sel   <= 1'b0;
         cfg.upper_nc <= 1'b0;
         cfg.lower_nc <= 1'b0;
         cfg.upper    <= pls_pkg::UPPER_RST;
         cfg.lower    <= pls_pkg::LOWER_RST;
         cfg.timeout  <= pls_pkg::TIMEOUT_RST;
      end else if (wr && prog) begin // [RQ10] [RQ11]
         unique case (req.adr)
            pls_pkg::OFS_CTRL: begin
               if (req.sel[0]) begin
                  cfg.mm_sel   <= req.dat[pls_pkg::CTRL_MM];
                  cfg.upper_nc <= req.dat[pls_pkg::CTRL_UP_NC];
                  cfg.lower_nc <= req.dat[pls_pkg::CTRL_LO_NC];
               end
            end
            pls_pkg::OFS_UPPER: begin
               cfg.upper <= upper_mrg[pls_pkg::POS_W-1:0];
            end
            pls_pkg::OFS_LOWER: begin
               cfg.lower <= lower_mrg[pls_pkg::POS_W-1:0];
            end
            pls_pkg::OFS_TIMEOUT: begin
               cfg.timeout <= merge(cfg.timeout, req.dat, req.sel);
            end
            default: begin
               cfg <= cfg;
            end
         endcase
      end
   end

   // ***********************************************************
   // interrupts
   // ***********************************************************
   assign irq_ev = {under && !under_q, over && !over_q, jam_set};

   // sticky status; a new event wins over a write-one clear
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat <= '0;
         irq_mask <= '0;
      end else begin
         if (lane0_hit(wr, req, pls_pkg::OFS_IRQ_STAT)) begin
            irq_stat <= (irq_stat & ~req.dat[pls_pkg::IRQ_W-1:0]) | irq_ev;
         end else begin
            irq_stat <= irq_stat | irq_ev;
         end
         if (lane0_hit(wr, req, pls_pkg::OFS_IRQ_MASK)) begin
            irq_mask <= req.dat[pls_pkg::IRQ_W-1:0];
         end
      end
   end
   assign irq_o = |(irq_stat & irq_mask);

   // ***********************************************************
   // read mux
   // ***********************************************************
   always_comb begin
      next_dat = 32'h0000_0000;
      unique case (req.adr)
         pls_pkg::OFS_CTRL: begin
            next_dat[pls_pkg::CTRL_MM]    = cfg.mm_sel;
            next_dat[pls_pkg::CTRL_UP_NC] = cfg.upper_nc;
            next_dat[pls_pkg::CTRL_LO_NC] = cfg.lower_nc;
         end
         pls_pkg::OFS_UPPER:    next_dat = {8'h00, cfg.upper};
         pls_pkg::OFS_LOWER:    next_dat = {8'h00, cfg.lower};
         pls_pkg::OFS_TIMEOUT:  next_dat = cfg.timeout;
         pls_pkg::OFS_POS:      next_dat = {8'h00, pos_o};
         pls_pkg::OFS_STATUS: begin
            next_dat[pls_pkg::ST_PROG]  = prog;
            next_dat[pls_pkg::ST_JAM]   = jam;
            next_dat[pls_pkg::ST_OVER]  = over;
            next_dat[pls_pkg::ST_UNDER] = under;
         end
         pls_pkg::OFS_IRQ_STAT: next_dat = {29'h0000_0000, irq_stat};
         pls_pkg::OFS_IRQ_MASK: next_dat = {29'h0000_0000, irq_mask};
         default:               next_dat = 32'h0000_0000; // unmapped and code read zero
      endcase
   end

   // read data registered with the ack
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wb_dat_o <= '0;
      end else if (rd_sel && !req.we) begin
         wb_dat_o <= next_dat;
      end
   end
endmodule : pls_top

// *** verification/pls_press_model.sv ***
// press side model: ram motor drive and a position transducer
`timescale 1ns/1ns
module pls_press_model (
   input  wire logic        mclk_i,
   input  wire logic        motor_i,
   input  wire logic        stall_i,
   input  wire logic        load_i,
   input  wire logic [23:0] start_i,
   output logic      [23:0] pos_o,
   output logic             motor_on_o
);
   logic [2:0] div = 3'h0;
   initial pos_o = 24'h000000;
   initial motor_on_o = 1'b0;
   // ram creeps one count every eight clocks so a synchronised word stays steady
   always @(posedge mclk_i) begin
      div <= div + 3'h1;
      motor_on_o <= motor_i;
      if (load_i) begin
         pos_o <= start_i;
      end else if (motor_i && !stall_i && div == 3'h7) begin
         pos_o <= pos_o + 24'h000001; // a jammed ram (stall) never moves
      end
   end
endmodule : pls_press_model

// *** verification/pls_top_props.sv ***
// checker for bus, mode, hold, relay and jam timing at the supervisor pins
`timescale 1ns/1ns
module pls_top_props (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic        hold_i,
   input wire logic        motor_on_i,
   input wire logic        relay_fitted_i,
   input wire logic [23:0] pos_o,
   input wire logic        upper_relay_o,
   input wire logic        lower_relay_o,
   input wire logic        relay_oe_o,
   input wire logic        prog_led_o,
   input wire logic        jam_err_o
);
   logic req;
   logic wr;
   // pins pass two sync flops and an output register, so windows are 4 to 5 cycles
   assign req = wb_cyc_i && wb_stb_i;
   assign wr  = req && wb_we_i;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack wider than one cycle");
   ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   prog_rise_a: assert property ($rose(prog_led_o) |-> $past(wr))
      else $error("program mode entered without a write");
   prog_fall_a: assert property ($fell(prog_led_o) |-> $past(wr))
      else $error("program mode left without a write");
   hold_freeze_a: assert property (hold_i && $past(hold_i) && $past(hold_i, 2) &&
      $past(hold_i, 3) && $past(hold_i, 4) |-> $stable(pos_o)) else $error("position moved in hold");
   oe_follow_a: assert property ($stable(relay_fitted_i) [*4] |-> relay_oe_o == relay_fitted_i)
      else $error("relay enable not following option");
   relay_off_a: assert property (!relay_fitted_i [*5] |-> !upper_relay_o && !lower_relay_o)
      else $error("relay driven without option");
   jam_latch_a: assert property (jam_err_o && !wr && !$past(wr) |=> jam_err_o)
      else $error("jam cleared without acknowledge");
   jam_cause_a: assert property ($rose(jam_err_o) |-> $past(motor_on_i, 3))
      else $error("jam raised without motor power");
endmodule : pls_top_props

// *** verification/position_limit_supervisor_tb.sv ***
// self-checking testbench for the position limit supervisor
`timescale 1ns/1ns
module position_limit_supervisor_tb;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, load = 1'b1;
   logic        hold = 1'b0, motor = 1'b0, stall = 1'b0, fitted = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h00000000, rdat;
   logic [23:0] start = 24'h000000, pos_i, pos_o;
   logic        ack, motor_on, up, lo, oe, led, jam, irq;
   int          err_count = 0, n_checks = 0;
   always #20 mclk = ~mclk;
   pls_press_model u_press (.mclk_i(mclk), .motor_i(motor), .stall_i(stall), .load_i(load),
      .start_i(start), .pos_o(pos_i), .motor_on_o(motor_on));
   pls_top u_dut (.mclk_i(mclk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pos_i(pos_i), .hold_i(hold), .motor_on_i(motor_on), .relay_fitted_i(fitted), .pos_o(pos_o),
      .upper_relay_o(up), .lower_relay_o(lo), .relay_oe_o(oe), .prog_led_o(led), .jam_err_o(jam),
      .irq_o(irq));
   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // classic cycle; ends on a falling edge so the ack edge's updates are visible
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(negedge mclk);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, q);
      chk(q, e);
   endtask : rd
   task automatic setpos(input logic [23:0] v);
      @(posedge mclk);
      start <= v;
      load <= 1'b1;
      @(posedge mclk);
      load <= 1'b0;
      tick(6);
   endtask : setpos
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_mode;
      chk({led, jam}, 2'b00);
      rd(pls_pkg::OFS_TIMEOUT, 32'h0098_9680);
      rd(8'h24, 32'h0000_0000);
      wr(pls_pkg::OFS_UPPER, 32'h0000_0100);
      rd(pls_pkg::OFS_UPPER, 32'h007F_FFFF);
      wr(pls_pkg::OFS_CODE, pls_pkg::ACCESS_CODE_DEF ^ 32'h0000_0001);
      chk(led, 1'b0);
      wr(pls_pkg::OFS_CODE, pls_pkg::ACCESS_CODE_DEF);
      chk(led, 1'b1);
      wr(pls_pkg::OFS_UPPER, 32'h0000_03E8);
      wr(pls_pkg::OFS_LOWER, 32'h00FF_FC18);
      wr(pls_pkg::OFS_TIMEOUT, 32'h0000_0014);
      rd(pls_pkg::OFS_UPPER, 32'h0000_03E8);
   endtask : t_mode
   task automatic t_limits;
      setpos(24'h000000);
      chk({up, lo, oe}, 3'b000);
      fitted <= 1'b1;
      tick(6);
      chk({up, lo, oe}, 3'b111);
      setpos(24'h0003E8);
      chk({up, lo}, 2'b11);
      setpos(24'h0003E9);
      chk({up, lo}, 2'b01);
      setpos(24'hFFFC17);
      chk({up, lo}, 2'b10);
      rd(pls_pkg::OFS_IRQ_STAT, 32'h0000_0006);
      chk(irq, 1'b0);
      wr(pls_pkg::OFS_IRQ_MASK, 32'h0000_0006);
      chk(irq, 1'b1);
      wr(pls_pkg::OFS_IRQ_STAT, 32'h0000_0006);
      chk(irq, 1'b0);
   endtask : t_limits
   task automatic t_setup;
      setpos(24'h000000);
      wr(pls_pkg::OFS_CTRL, 32'h0000_0002);
      tick(3);
      chk({up, lo}, 2'b01);
      wr(pls_pkg::OFS_CTRL, 32'h0000_0004);
      tick(3);
      chk({up, lo}, 2'b10);
      setpos(24'h0003E8);
      wr(pls_pkg::OFS_CTRL, 32'h0000_0001);
      tick(4);
      chk(pos_o, 24'h006338);
      wr(pls_pkg::OFS_CTRL, 32'h0000_0000);
      setpos(24'h000123);
      hold <= 1'b1;
      tick(6);
      setpos(24'h000456);
      chk(pos_o, 24'h000123);
      hold <= 1'b0;
      tick(6);
      chk(pos_o, 24'h000456);
      rd(pls_pkg::OFS_POS, 32'h0000_0456);
   endtask : t_setup
   task automatic t_jam;
      setpos(24'h000000);
      wr(pls_pkg::OFS_IRQ_STAT, 32'h0000_0007);
      wr(pls_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      tick(1);
      motor <= 1'b1;
      tick(60);
      chk(jam, 1'b0);
      motor <= 1'b0;
      stall <= 1'b1;
      tick(6);
      motor <= 1'b1;
      tick(15);
      chk(jam, 1'b0);
      tick(25);
      chk({jam, irq, up, lo}, 4'b1100);
      motor <= 1'b0;
      tick(10);
      chk(jam, 1'b1);
      rd(pls_pkg::OFS_STATUS, 32'h0000_0003);
      wr(pls_pkg::OFS_CTRL, 32'h0000_0010);
      tick(3);
      chk({jam, up, lo}, 3'b011);
      wr(pls_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      chk(irq, 1'b0);
      wr(pls_pkg::OFS_CTRL, 32'h0000_0008);
      chk(led, 1'b0);
      wr(pls_pkg::OFS_UPPER, 32'h0000_0005);
      rd(pls_pkg::OFS_UPPER, 32'h0000_03E8);
   endtask : t_jam
   // main sequence; whole run is well under two thousand cycles
   initial begin
      tick(2);
      rst_b <= 1'b1;
      load <= 1'b0;
      tick(6);
      t_mode();
      t_limits();
      t_setup();
      t_jam();
      conclude();
   end
   // watchdog against a hung handshake
   initial begin
      tick(6000);
      err_count++;
      conclude();
   end
endmodule : position_limit_supervisor_tb
bind pls_top pls_top_props u_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .hold_i(hold_i),
   .motor_on_i(motor_on_i), .relay_fitted_i(relay_fitted_i), .pos_o(pos_o),
   .upper_relay_o(upper_relay_o), .lower_relay_o(lower_relay_o), .relay_oe_o(relay_oe_o),
   .prog_led_o(prog_led_o), .jam_err_o(jam_err_o));
